/* mvo_cfg.svh */
// constants of the motor vector output stage: offsets, fields, task and output codes
`ifndef MVO_CFG_SVH
`define MVO_CFG_SVH
`define MVO_OFF_FMODE 8'h00
`define MVO_OFF_EMODE 8'h04
`define MVO_OFF_TASK 8'h08
`define MVO_OFF_ALPHA 8'h0C
`define MVO_OFF_BETA 8'h10
`define MVO_OFF_VDC 8'h14
`define MVO_OFF_PRD 8'h18
`define MVO_OFF_OMEGA 8'h1C
`define MVO_OFF_SHSPD 8'h20
`define MVO_OFF_MINPLS 8'h24
`define MVO_OFF_RES_A 8'h28
`define MVO_OFF_RES_B 8'h2C
`define MVO_OFF_RES_C 8'h30
`define MVO_OFF_SECT 8'h34
`define MVO_OFF_STAT 8'h38
`define MVO_OFF_CMPUV 8'h3C
`define MVO_OFF_CMPW 8'h40
`define MVO_FB_TWO_PHASE_MODULATION_ENABLE 0
`define MVO_FB_MREGDIS 1
`define MVO_FB_PHCVDIS 2
`define MVO_FB_TWO_PHASE_DUTY_SELECT 3
`define MVO_FB_SPWMEN 4
`define MVO_FB_IDMODE 5
`define MVO_FB_SPWMMD 7
`define MVO_EB_OCRMD 0
`define MVO_TASK_OC1 4'h0
`define MVO_TASK_OC2 4'h9
`define MVO_TASK_ICL 4'hB
`define MVO_OUTCR_NORMAL 9'h1FF
`define MVO_OUTCR_SHIFT 9'h0FF
`define MVO_OUTCR_OFF 9'h000
`define MVO_INV_SQRT3 32'h49E69D16
`define MVO_HALF_SQRT3 32'h6ED9EBA1
`define MVO_HALF 32'h40000000
`define MVO_DIV_CYCLES 6'h20
`endif

/* mvo_engine.sv */
// motor vector output stage: inverse Clarke and output control tasks
`include "mvo_cfg.svh"
module mvo_engine #(
    parameter int DIV_CYCLES = 32
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    // axi4-lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // to pwm unit
    output mvo_pkg::mvo_pwm_s pwm,
    output logic pwm_update
);
    // the quotient register is 32 bits, so no other step count can serve
    if (DIV_CYCLES != 32)
    begin : g_bad_cycles
        $error("DIV_CYCLES must be 32");
    end

    // ************************************************
    // registers
    // ************************************************
    logic [8:0] function_mode_reg;
    logic [1:0] engine_mode_reg;
    logic [31:0] alpha_voltage_work;
    logic [31:0] beta_voltage_work;
    logic [15:0] supply_voltage_value;
    logic [15:0] pwm_period_value;
    logic [15:0] rotation_speed;
    logic [15:0] shift_switch_speed;
    logic [15:0] minimum_pulse_width;
    logic [31:0] work_result_a;
    logic [31:0] work_result_b;
    logic [31:0] work_result_c;
    logic [3:0] current_sector;
    logic [3:0] previous_sector;
    logic [3:0] task_sel;
    logic busy;
    logic task_start;
    mvo_pkg::mvo_state_e state;

    logic aw_hold;
    logic w_hold;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_write;
    assign do_write = aw_hold && w_hold && !s_axi_bvalid;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
                old[8*i +: 8] = nw[8*i +: 8];
        end
        return old;
    endfunction : merge

    function automatic logic [31:0] magnitude(input logic [31:0] v);
        return v[31] ? 32'(-v) : v;
    endfunction : magnitude

    // q1.31 by q1.31 signed product, keeps q1.31
    function automatic logic [31:0] qmul(input logic [31:0] a, input logic [31:0] b);
        logic signed [63:0] p;
        p = $signed(a) * $signed(b);
        return p[62:31];
    endfunction : qmul

    // ************************************************
    // axi4-lite slave
    // ************************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end
        else if (clk_en)
        begin
            s_axi_awready <= !aw_hold;
            s_axi_wready <= !w_hold;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold <= 1'b1;
                s_axi_awready <= 1'b0;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold <= 1'b1;
                s_axi_wready <= 1'b0;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_hold <= 1'b0;
                w_hold <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr > `MVO_OFF_CMPW || aw_addr[1:0] != 2'h0) ? 2'h2 : 2'h0;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            function_mode_reg <= 9'h000;
            engine_mode_reg <= 2'h0;
            alpha_voltage_work <= 32'h0;
            beta_voltage_work <= 32'h0;
            supply_voltage_value <= 16'h7FFF;
            pwm_period_value <= 16'h0000;
            rotation_speed <= 16'h0000;
            shift_switch_speed <= 16'h0000;
            minimum_pulse_width <= 16'h0000;
            task_sel <= 4'h0;
            task_start <= 1'b0;
        end
        else if (clk_en)
        begin
            task_start <= 1'b0;
            if (do_write)
            begin
                if (aw_addr == `MVO_OFF_FMODE)
                    function_mode_reg <= 9'(merge({23'h0, function_mode_reg}, w_data, w_strb));
                else if (aw_addr == `MVO_OFF_EMODE)
                    engine_mode_reg <= 2'(merge({30'h0, engine_mode_reg}, w_data, w_strb));
                else if (aw_addr == `MVO_OFF_TASK && !busy)
                begin
                    // a task write while busy is dropped; writes to alpha, beta and the other inputs still land during a task
                    task_sel <= w_data[3:0];
                    task_start <= w_strb[0];
                end
                else if (aw_addr == `MVO_OFF_ALPHA)
                    alpha_voltage_work <= merge(alpha_voltage_work, w_data, w_strb);
                else if (aw_addr == `MVO_OFF_BETA)
                    beta_voltage_work <= merge(beta_voltage_work, w_data, w_strb);
                else if (aw_addr == `MVO_OFF_VDC)
                    supply_voltage_value <= 16'(merge({16'h0, supply_voltage_value}, w_data,
                                                      w_strb));
                else if (aw_addr == `MVO_OFF_PRD)
                    pwm_period_value <= 16'(merge({16'h0, pwm_period_value}, w_data,
                                                  w_strb));
                else if (aw_addr == `MVO_OFF_OMEGA)
                    rotation_speed <= 16'(merge({16'h0, rotation_speed}, w_data, w_strb));
                else if (aw_addr == `MVO_OFF_SHSPD)
                    shift_switch_speed <= 16'(merge({16'h0, shift_switch_speed}, w_data,
                                                    w_strb));
                else if (aw_addr == `MVO_OFF_MINPLS)
                    minimum_pulse_width <= 16'(merge({16'h0, minimum_pulse_width}, w_data,
                                                     w_strb));
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h0;
        end
        else if (clk_en)
        begin
            s_axi_arready <= 1'b0;
            if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
            else if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid)
            begin
                s_axi_arready <= 1'b1;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'h0;
                if (s_axi_araddr == `MVO_OFF_FMODE)
                    s_axi_rdata <= {23'h0, function_mode_reg};
                else if (s_axi_araddr == `MVO_OFF_EMODE)
                    s_axi_rdata <= {30'h0, engine_mode_reg};
                else if (s_axi_araddr == `MVO_OFF_TASK)
                    s_axi_rdata <= {27'h0, busy, task_sel};
                else if (s_axi_araddr == `MVO_OFF_ALPHA)
                    s_axi_rdata <= alpha_voltage_work;
                else if (s_axi_araddr == `MVO_OFF_BETA)
                    s_axi_rdata <= beta_voltage_work;
                else if (s_axi_araddr == `MVO_OFF_VDC)
                    s_axi_rdata <= {16'h0, supply_voltage_value};
                else if (s_axi_araddr == `MVO_OFF_PRD)
                    s_axi_rdata <= {16'h0, pwm_period_value};
                else if (s_axi_araddr == `MVO_OFF_OMEGA)
                    s_axi_rdata <= {16'h0, rotation_speed};
                else if (s_axi_araddr == `MVO_OFF_SHSPD)
                    s_axi_rdata <= {16'h0, shift_switch_speed};
                else if (s_axi_araddr == `MVO_OFF_MINPLS)
                    s_axi_rdata <= {16'h0, minimum_pulse_width};
                else if (s_axi_araddr == `MVO_OFF_RES_A)
                    s_axi_rdata <= work_result_a;
                else if (s_axi_araddr == `MVO_OFF_RES_B)
                    s_axi_rdata <= work_result_b;
                else if (s_axi_araddr == `MVO_OFF_RES_C)
                    s_axi_rdata <= work_result_c;
                else if (s_axi_araddr == `MVO_OFF_SECT)
                    s_axi_rdata <= {24'h0, previous_sector, current_sector};
                else if (s_axi_araddr == `MVO_OFF_STAT)
                    s_axi_rdata <= {20'h0, pwm.outcr, pwm.emg_return, pwm.low_speed,
                                    pwm.small_pulse};
                else if (s_axi_araddr == `MVO_OFF_CMPUV)
                    s_axi_rdata <= {pwm.cmp_v, pwm.cmp_u};
                else if (s_axi_araddr == `MVO_OFF_CMPW)
                    s_axi_rdata <= {16'h0, pwm.cmp_w};
                else
                begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= 2'h2;
                end
            end
        end
    end

    // ************************************************
    // inverse clarke numerators and sector
    // ************************************************
    logic [31:0] abs_a;
    logic [31:0] abs_b;
    logic [31:0] num_a;
    logic [31:0] num_b;
    logic [31:0] num_c;
    logic [3:0] next_sector;
    logic a_ge;
    logic a_gt;
    always_comb
    begin
        abs_a = magnitude(alpha_voltage_work);
        abs_b = magnitude(beta_voltage_work);
        a_ge = abs_a >= qmul(abs_b, `MVO_INV_SQRT3);
        a_gt = qmul(abs_a, `MVO_INV_SQRT3) >= abs_b;
        if (!alpha_voltage_work[31] && !beta_voltage_work[31])
            next_sector = a_ge ? (a_gt ? 4'h0 : 4'h1) : 4'h2;
        else if (alpha_voltage_work[31] && !beta_voltage_work[31])
            next_sector = !a_ge ? 4'h3 : (!a_gt ? 4'h4 : 4'h5);
        else if (alpha_voltage_work[31])
            next_sector = a_ge ? (a_gt ? 4'h6 : 4'h7) : 4'h8;
        else
            next_sector = !a_ge ? 4'h9 : (!a_gt ? 4'hA : 4'hB);
        // two-phase modulation bit two_phase_modulation_enable is deliberately not read here
        num_a = alpha_voltage_work;
        if (function_mode_reg[`MVO_FB_TWO_PHASE_DUTY_SELECT])
        begin
            num_b = beta_voltage_work;
            num_c = 32'h0;
        end
        else
        begin
            num_b = 32'($signed(-alpha_voltage_work) >>> 1)
                    + qmul(beta_voltage_work, `MVO_HALF_SQRT3);
            num_c = 32'($signed(-alpha_voltage_work) >>> 1)
                    - qmul(beta_voltage_work, `MVO_HALF_SQRT3);
        end
    end

    // ************************************************
    // task sequencer with serial divider
    // ************************************************
    logic [1:0] div_idx;
    logic [5:0] div_cnt;
    logic [47:0] rem;
    logic [31:0] quo;
    logic [31:0] dividend;
    logic [31:0] duty;
    logic signed [47:0] next_rem;
    assign dividend = div_idx == 2'h0 ? num_a : (div_idx == 2'h1 ? num_b : num_c);
    // divisor at 2^17 scale so the quotient comes out as q1.31
    assign next_rem = $signed({rem[46:0], 1'b0}) - $signed({15'h0, supply_voltage_value, 17'h0});
    // signed quotient q1.31 plus one half, clamped to 0..1
    always_comb
    begin
        logic signed [33:0] s;
        s = dividend[31] ? -$signed({2'b00, quo}) : $signed({2'b00, quo});
        s = s + $signed({2'b00, `MVO_HALF});
        if (s[33])
            duty = 32'h0;
        else if (s > 34'sh080000000)
            duty = 32'h80000000;
        else
            duty = s[31:0];
    end

    assign busy = state != mvo_pkg::MVO_IDLE;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state <= mvo_pkg::MVO_IDLE;
            div_idx <= 2'h0;
            div_cnt <= 6'h0;
            rem <= 48'h0;
            quo <= 32'h0;
            work_result_a <= 32'h0;
            work_result_b <= 32'h0;
            work_result_c <= 32'h0;
            current_sector <= 4'h0;
            previous_sector <= 4'h0;
        end
        else if (clk_en)
        begin
            case (state)
                mvo_pkg::MVO_IDLE:
                begin
                    if (task_start && task_sel == `MVO_TASK_ICL)
                    begin
                        if (!function_mode_reg[`MVO_FB_MREGDIS])
                            previous_sector <= current_sector;
                        current_sector <= next_sector;
                        div_idx <= 2'h0;
                        state <= function_mode_reg[`MVO_FB_PHCVDIS] ? mvo_pkg::MVO_IDLE
                                 : mvo_pkg::MVO_PREP;
                    end
                    else if (task_start && (task_sel == `MVO_TASK_OC1
                             || task_sel == `MVO_TASK_OC2))
                        state <= mvo_pkg::MVO_OUT;
                end
                mvo_pkg::MVO_PREP:
                begin
                    rem <= {16'h0, magnitude(dividend)};
                    quo <= 32'h0;
                    div_cnt <= 6'h0;
                    state <= mvo_pkg::MVO_DIV;
                end
                mvo_pkg::MVO_DIV:
                begin
                    // restoring division, one quotient bit per cycle
                    if (!next_rem[47])
                        rem <= next_rem;
                    else
                        rem <= {rem[46:0], 1'b0};
                    quo <= {quo[30:0], !next_rem[47]};
                    div_cnt <= div_cnt + 6'h1;
                    if (div_cnt == `MVO_DIV_CYCLES - 6'h1)
                        state <= mvo_pkg::MVO_STORE;
                end
                mvo_pkg::MVO_STORE:
                begin
                    if (div_idx == 2'h0)
                        work_result_a <= duty;
                    else if (div_idx == 2'h1)
                        work_result_b <= duty;
                    else
                        work_result_c <= function_mode_reg[`MVO_FB_TWO_PHASE_DUTY_SELECT] ? 32'h0 : duty;
                    div_idx <= div_idx + 2'h1;
                    state <= div_idx == 2'h2 ? mvo_pkg::MVO_IDLE : mvo_pkg::MVO_PREP;
                end
                default:
                    state <= mvo_pkg::MVO_IDLE;
            endcase
        end
    end

    // ************************************************
    // output control
    // ************************************************
    function automatic logic [15:0] to_compare(input logic [31:0] d, input logic [15:0] prd);
        logic [47:0] p;
        p = {16'h0, d} * {32'h0, prd};
        return p[47:31] > {1'b0, prd} ? prd : p[46:31];
    endfunction : to_compare

    logic [15:0] cu;
    logic [15:0] cv;
    logic [15:0] cw;
    logic shift_on;
    logic narrow;
    always_comb
    begin
        cu = to_compare(work_result_a, pwm_period_value);
        cv = to_compare(work_result_b, pwm_period_value);
        cw = to_compare(work_result_c, pwm_period_value);
        if (task_sel == `MVO_TASK_OC1)
            shift_on = function_mode_reg[`MVO_FB_SPWMEN]
                       && ($signed(rotation_speed) < $signed(shift_switch_speed));
        else
            shift_on = function_mode_reg[`MVO_FB_SPWMEN]
                       && function_mode_reg[`MVO_FB_SPWMMD +: 2] != 2'h0;
        narrow = (cu != 16'h0 && cu < minimum_pulse_width)
                 || (cv != 16'h0 && cv < minimum_pulse_width)
                 || (cw != 16'h0 && cw < minimum_pulse_width);
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pwm <= '0;
            pwm_update <= 1'b0;
        end
        else if (clk_en)
        begin
            pwm_update <= 1'b0;
            if (state == mvo_pkg::MVO_OUT)
            begin
                // every field loads on one edge so the pwm unit sees a whole set
                pwm.cmp_u <= cu;
                pwm.cmp_v <= cv;
                pwm.cmp_w <= cw;
                if (engine_mode_reg == 2'h0)
                    pwm.outcr <= `MVO_OUTCR_OFF;
                else
                    pwm.outcr <= shift_on ? `MVO_OUTCR_SHIFT : `MVO_OUTCR_NORMAL;
                pwm.emg_return <= engine_mode_reg == 2'h3;
                pwm.low_speed <= $signed(rotation_speed) < $signed(shift_switch_speed);
                pwm.small_pulse <= narrow;
                pwm_update <= 1'b1;
            end
        end
    end
endmodule : mvo_engine

/* mvo_engine_asserts.sv */
// port checker of the motor vector output stage
module mvo_engine_asserts (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_bvalid,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // pwm side
    input mvo_pkg::mvo_pwm_s pwm,
    input wire logic pwm_update
);
    // ****************
    // properties
    // ****************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_write_answer: assert property ($rose(s_axi_awvalid) |-> ##[1:4] s_axi_bvalid)
        else $error("write not answered");
    a_read_answer: assert property ($rose(s_axi_arvalid) |-> ##[1:4] s_axi_rvalid)
        else $error("read not answered");
    a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
        else $error("read data moved");
    // reset clears the set, so the edge after release is excluded
    a_set_atomic: assert property ($past(aresetn) && !pwm_update |-> $stable(pwm))
        else $error("pwm set moved without update");
    a_update_single: assert property (pwm_update |=> !pwm_update)
        else $error("update pulse too long");
    a_outcr_code: assert property (pwm_update
        |-> pwm.outcr inside {9'h000, 9'h0FF, 9'h1FF})
        else $error("bad output control code");
    a_emg_output: assert property (pwm.emg_return |-> pwm.outcr != 9'h000)
        else $error("emergency return with outputs off");
    a_small_nonzero: assert property (pwm.small_pulse
        |-> (pwm.cmp_u | pwm.cmp_v | pwm.cmp_w) != 16'h0000)
        else $error("small pulse flag with no pulse");
    a_update_cause: assert property (pwm_update
        |-> $past(s_axi_bvalid, 2) || $past(s_axi_bvalid, 3) || $past(s_axi_bvalid, 4))
        else $error("update without task write");
    cover property (pwm_update && pwm.outcr == 9'h0FF);
    cover property (pwm_update && pwm.emg_return);
    cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule : mvo_engine_asserts
bind mvo_engine mvo_engine_asserts u_chk (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_bvalid(s_axi_bvalid), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .pwm(pwm), .pwm_update(pwm_update));

/* mvo_pkg.sv */
// types of the motor vector output stage
package mvo_pkg;
    typedef enum logic [2:0] {
        MVO_IDLE = 3'h0,
        MVO_PREP = 3'h1,
        MVO_DIV = 3'h3,
        MVO_STORE = 3'h2,
        MVO_OUT = 3'h6
    } mvo_state_e;
    typedef struct packed {
        logic [15:0] cmp_u;
        logic [15:0] cmp_v;
        logic [15:0] cmp_w;
        logic [8:0] outcr;
        logic emg_return;
        logic low_speed;
        logic small_pulse;
    } mvo_pwm_s;
endpackage : mvo_pkg

/* mvo_pwm_sink.sv */
// pwm unit model: latches each published compare set
module mvo_pwm_sink (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // from engine
    input mvo_pkg::mvo_pwm_s pwm,
    input wire logic pwm_update,
    // latched set
    output mvo_pkg::mvo_pwm_s taken,
    output int n_taken
);
    timeunit 1ns;
    timeprecision 1ns;
    // the unit reads the set only at the strobe, so a torn set would show here
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            taken <= '0;
            n_taken <= 0;
        end
        else if (pwm_update)
        begin
            taken <= pwm;
            n_taken <= n_taken + 1;
        end
    end
endmodule : mvo_pwm_sink

/* tb_mvo_engine.sv */
// testbench of the motor vector output stage
module tb_mvo_engine;
    timeunit 1ns;
    timeprecision 1ns;
    // single-shunt detection code, plain default
    localparam logic [1:0] ONE_SHUNT = 2'h1;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h00000000;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, pwm_update;
    logic [1:0] bresp, rresp, rs;
    logic [31:0] rdata, rd;
    mvo_pkg::mvo_pwm_s pwm, taken;
    int n_taken, m;
    int n_mismatch = 0;
    int n_compared = 0;
    always #25 aclk = ~aclk;
    mvo_engine dut (.aclk(aclk), .aresetn(aresetn), .clk_en(1'b1),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .pwm(pwm), .pwm_update(pwm_update));
    mvo_pwm_sink sink (.aclk(aclk), .aresetn(aresetn), .pwm(pwm), .pwm_update(pwm_update),
        .taken(taken), .n_taken(n_taken));
    // ****************
    // tasks
    // ****************
    task automatic finish_test();
        $display("compared %0d, mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : finish_test
    task automatic hang();
        n_mismatch++;
        $display("wrong value at %0t: no answer", $time);
        finish_test();
    endtask : hang
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (i = 0; i < 40; i++)
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        rs = bresp;
        bready <= 1'b0;
        if (i == 40) hang();
    endtask : wr
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        int i;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (i = 0; i < 40; i++)
        begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
        if (i == 40) hang();
        if (e !== 32'hFFFFFFFF) chk(rd, e);
    endtask : rchk
    // busy is polled, never assumed from a cycle count
    task automatic run(input logic [3:0] t);
        int i;
        wr(8'h08, {28'h0000000, t});
        for (i = 0; i < 300; i++)
        begin
            rchk(8'h08, 32'hFFFFFFFF);
            if (rd[4] === 1'b0) break;
        end
        if (i == 300) hang();
    endtask : run
    task automatic oc(input logic [3:0] t, input logic [8:0] ocr, input logic emg);
        run(t);
        chk(32'(taken.outcr), 32'(ocr));
        chk(32'(taken.emg_return), 32'(emg));
    endtask : oc
    task automatic fm(input logic [1:0] md);
        wr(8'h00, {23'h000000, md, ONE_SHUNT, 5'h10});
    endtask : fm
    // ****************
    // sequence
    // ****************
    initial
    begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rchk(8'h34, 32'h00000000);
        rchk(8'h38, 32'h00000000);
        $display("reset test done");
        wr(8'h00, 32'h00000001);
        wr(8'h14, 32'h00004000);
        wr(8'h10, 32'h20000000);
        run(4'hB);
        rchk(8'h28, 32'h40000000);
        wr(8'h0C, 32'hE0000000);
        wr(8'h10, 32'h00000000);
        run(4'hB);
        rchk(8'h34, 32'h00000025);
        rchk(8'h28, 32'h00000000);
        rchk(8'h2C, 32'h60000000);
        rchk(8'h30, 32'h60000000);
        wr(8'h00, 32'h00000002);
        wr(8'h0C, 32'h20000000);
        run(4'hB);
        rchk(8'h34, 32'h00000020);
        rchk(8'h28, 32'h80000000);
        rchk(8'h2C, 32'h20000000);
        $display("inverse clarke test done");
        wr(8'h18, 32'h00001000);
        wr(8'h04, 32'h00000001);
        oc(4'h0, 9'h1FF, 1'b0);
        rchk(8'h3C, 32'h04001000);
        rchk(8'h40, 32'h00000400);
        fm(2'h0);
        wr(8'h1C, 32'h00000100);
        wr(8'h20, 32'h00000200);
        oc(4'h0, 9'h0FF, 1'b0);
        chk(32'(taken.low_speed), 32'h00000001);
        wr(8'h1C, 32'h00000300);
        oc(4'h0, 9'h1FF, 1'b0);
        oc(4'h9, 9'h1FF, 1'b0);
        for (m = 1; m < 4; m++)
        begin
            fm(m[1:0]);
            oc(4'h9, 9'h0FF, 1'b0);
        end
        wr(8'h04, 32'h00000000);
        oc(4'h0, 9'h000, 1'b0);
        wr(8'h04, 32'h00000003);
        oc(4'h0, 9'h1FF, 1'b1);
        wr(8'h24, 32'h00000500);
        run(4'h0);
        chk(32'(taken.small_pulse), 32'h00000001);
        wr(8'h24, 32'h00000400);
        run(4'h0);
        chk(32'(taken.small_pulse), 32'h00000000);
        chk(32'(n_taken), 32'h0000000B);
        wr(8'h00, 32'h00000008);
        wr(8'h10, 32'hE0000000);
        run(4'hB);
        rchk(8'h28, 32'h80000000);
        rchk(8'h2C, 32'h00000000);
        wr(8'h00, 32'h00000004);
        wr(8'h0C, 32'hE0000000);
        run(4'hB);
        rchk(8'h34, 32'h000000A7);
        rchk(8'h28, 32'h80000000);
        $display("output control test done");
        rchk(8'h44, 32'h00000000);
        chk(32'(rs), 32'h00000002);
        wr(8'h02, 32'h00000000);
        chk(32'(rs), 32'h00000002);
        $display("bus error test done");
        finish_test();
    end
endmodule : tb_mvo_engine
